//--- src/sll_link_status.sv
// Lane status register bank with Avalon-MM slave
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module sll_link_status #(
  parameter int NUM_LANES = sll_pkg::NUM_LANES,
  parameter logic [7:0] THRESHOLD_INIT = sll_pkg::THRESHOLD_RESET
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [sll_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [sll_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [sll_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input sll_pkg::sll_lane_in_t laneIn [NUM_LANES],
  output logic [7:0] errorCountThreshold,
  output logic skipAlignmentSequence
);
  localparam int CNT_W = sll_pkg::CNT_W;
  localparam int SEL_W = (NUM_LANES > 1) ? $clog2(NUM_LANES) : 1;
  localparam int IDX_W = sll_pkg::IDX_W;
  localparam logic [IDX_W-1:0] LANE_SPAN = IDX_W'(NUM_LANES);
  localparam logic [IDX_W-1:0] CNT_SPAN = IDX_W'(4 * NUM_LANES);

  // Bus handshake state
  logic ack_reg;
  logic ack_next;
  logic [sll_pkg::DATA_W-1:0] rdata_reg;
  logic [sll_pkg::DATA_W-1:0] rdata_next;

  // Software settings
  logic [7:0] thresh_reg;
  logic [7:0] thresh_next;
  logic skip_reg;
  logic skip_next;
  logic clear_reg;
  logic clear_next;

  // Lane results
  logic [7:0] laneStatus [NUM_LANES];
  logic [sll_pkg::ERR_TYPES*CNT_W-1:0] laneCounts [NUM_LANES];

  // Request decode
  wire reqActive = avs_read | avs_write;
  wire firstCycle = reqActive & ~ack_reg;
  wire finalCycle = reqActive & ack_reg;
  wire [IDX_W-1:0] wordIdx = avs_address[sll_pkg::ADDR_W-1:2];
  wire aligned = (avs_address[1:0] == 2'b00);
  wire [IDX_W-1:0] laneOff = wordIdx - sll_pkg::IDX_LANE0_HEALTH;
  wire [IDX_W-1:0] cntOff = wordIdx - sll_pkg::IDX_COUNT0;
  wire hitLane = aligned && (wordIdx >= sll_pkg::IDX_LANE0_HEALTH) && (laneOff < LANE_SPAN);
  wire hitThresh = aligned && (wordIdx == sll_pkg::IDX_THRESHOLD);
  wire hitCtrl = aligned && (wordIdx == sll_pkg::IDX_CONTROL);
  wire hitCnt = aligned && (wordIdx >= sll_pkg::IDX_COUNT0) && (cntOff < CNT_SPAN)
    && (cntOff[1:0] != 2'b11);
  wire [SEL_W-1:0] laneSel = laneOff[SEL_W-1:0];
  wire [SEL_W-1:0] cntLane = cntOff[SEL_W+1:2];
  wire [1:0] cntType = cntOff[1:0];

  // Selected read values
  wire [7:0] selStatus = laneStatus[laneSel];
  wire [sll_pkg::ERR_TYPES*CNT_W-1:0] selCounts = laneCounts[cntLane];
  wire [CNT_W-1:0] selCount = (cntType == 2'h0) ? selCounts[2*CNT_W +: CNT_W] :
    (cntType == 2'h1) ? selCounts[CNT_W +: CNT_W] : selCounts[0 +: CNT_W];
  wire [sll_pkg::DATA_W-1:0] ctrlWord = {30'h00000000, clear_reg, skip_reg};

  // Read data of the addressed register, zero when unmapped
  wire [sll_pkg::DATA_W-1:0] readWord =
    hitLane ? {24'h000000, selStatus} : // RULE10
    hitThresh ? {24'h000000, thresh_reg} :
    hitCtrl ? ctrlWord :
    hitCnt ? {24'h000000, selCount} :
    32'h00000000;

  // Write strobes, lane status writes fall through silently
  wire doWrite = finalCycle & avs_write & avs_byteenable[0];
  wire wrThresh = doWrite & hitThresh;
  wire wrCtrl = doWrite & hitCtrl;

  // One wait cycle, answer on the second
  assign ack_next = firstCycle;
  assign rdata_next = (firstCycle & avs_read) ? readWord : rdata_reg;
  assign thresh_next = wrThresh ? avs_writedata[7:0] : thresh_reg;
  assign skip_next = wrCtrl ? avs_writedata[sll_pkg::CTRL_SKIP_BIT] : skip_reg;
  // Clear request is a single-cycle pulse
  assign clear_next = wrCtrl & avs_writedata[sll_pkg::CTRL_CLEAR_BIT];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      thresh_reg <= THRESHOLD_INIT;
      skip_reg <= sll_pkg::CTRL_SKIP_RESET;
      clear_reg <= 1'b0;
    end else begin
      thresh_reg <= thresh_next;
      skip_reg <= skip_next;
      clear_reg <= clear_next;
    end
  end

  assign avs_waitrequest = firstCycle;
  assign avs_readdata = rdata_reg;
  assign errorCountThreshold = thresh_reg;
  // Status bits still report; software masks them when skipping
  assign skipAlignmentSequence = skip_reg; // RULE9

  // One status block per lane
  genvar n;
  generate
    for (n = 0; n < NUM_LANES; n++) begin : g_lane
      sll_lane_status #(
        .CNT_W(CNT_W)
      ) u_lane (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .laneIn(laneIn[n]),
        .threshold(thresh_reg),
        .clearCounts(clear_reg),
        .statusByte(laneStatus[n]),
        .counts(laneCounts[n])
      );
    end
  endgenerate

  // Checks on the bus side
  wait_bound_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reqActive |-> ##[0:1] !avs_waitrequest)
    else $error("request not answered within one wait cycle");

  lane_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
    avs_read && !avs_waitrequest && hitLane && $past(avs_read)
    |-> avs_readdata == {24'h000000, $past(selStatus)})
    else $error("lane register read returned wrong lane");

  lane6_addr_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
    (wordIdx == sll_pkg::IDX_LANE6_HEALTH) && aligned |-> hitLane && laneSel == SEL_W'(6))
    else $error("lane 6 register not at its index");

  lane7_addr_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
    (wordIdx == sll_pkg::IDX_LANE7_HEALTH) && aligned |-> hitLane && laneSel == SEL_W'(7))
    else $error("lane 7 register not at its index");

  status_ro_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE11
    avs_write && !avs_waitrequest && hitLane |=> thresh_reg == $past(thresh_reg)
      && skip_reg == $past(skip_reg))
    else $error("lane register write disturbed settings");

  thresh_wr_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE12
    wrThresh |=> errorCountThreshold == $past(avs_writedata[7:0]))
    else $error("threshold write not taken");

  clear_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clear_reg |=> !clear_reg || $past(wrCtrl))
    else $error("counter clear held longer than one cycle");

  unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    avs_read && !avs_waitrequest && !(hitLane || hitThresh || hitCtrl || hitCnt)
    |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

//--- src/sll_pkg.sv
// Package for the per-lane serial link status register bank
// Functional notes
// (RULE1) Bit 7 reads 1 once disparity error count reaches threshold, else 0.
// (RULE2) Bit 6 reads 1 once invalid-code count reaches threshold, else 0.
// (RULE3) Bit 5 reads 1 once misplaced control character count reaches threshold.
// (RULE4) Bit 4 reports inter-lane deskew: 1 achieved, 0 failed.
// (RULE5) Bit 3 reports initial lane synchronization: 1 achieved, 0 lost.
// (RULE6) Bit 2 reports alignment configuration checksum: 1 correct, 0 incorrect.
// (RULE7) Bit 1 reports frame synchronization: 1 achieved, 0 lost.
// (RULE8) Bit 0 reports symbol lock, valid even when alignment sequence skipped.
// (RULE9) With alignment skipped, software ignores deskew, align, checksum, frame bits.
// (RULE10) One 8-bit status register per lane, same layout, lane 6 then 7.
// (RULE11) All status bits are read-only and reset to zero.
// (RULE12) Per-lane saturating counter per error type, compared with 8-bit threshold.
package sll_pkg;
  localparam int NUM_LANES = 8;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int IDX_W = 12;
  localparam int CNT_W = 8;
  localparam int ERR_TYPES = 3;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LANE0_HEALTH = 12'h4b0;
  localparam logic [IDX_W-1:0] IDX_LANE6_HEALTH = 12'h4b6;
  localparam logic [IDX_W-1:0] IDX_LANE7_HEALTH = 12'h4b7;
  localparam logic [IDX_W-1:0] IDX_THRESHOLD = 12'h4a0;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 12'h4a1;
  localparam logic [IDX_W-1:0] IDX_COUNT0 = 12'h4c0;

  // Status bit positions
  localparam int BIT_DISPARITY = 7;
  localparam int BIT_INVALID = 6;
  localparam int BIT_MISPLACED = 5;
  localparam int BIT_DESKEW = 4;
  localparam int BIT_ALIGN = 3;
  localparam int BIT_CHECKSUM = 2;
  localparam int BIT_FRAME = 1;
  localparam int BIT_SYMBOL = 0;

  // Control register fields
  localparam int CTRL_SKIP_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;

  // Reset values
  localparam logic [7:0] HEALTH_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'hff;
  localparam logic CTRL_SKIP_RESET = 1'b0;
  localparam logic [CNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_MAX = 8'hff;

  // Signals from one lane receiver
  typedef struct packed {
    logic disparityErr;
    logic invalidCodeErr;
    logic misplacedKErr;
    logic deskewOk;
    logic initAlignOk;
    logic checksumOk;
    logic frameLocked;
    logic symbolLocked;
  } sll_lane_in_t;
endpackage

//--- src/sll_lane_status.sv
// One lane: error counters, threshold compare and status byte
`timescale 1ns/1ps
module sll_lane_status #(
  parameter int CNT_W = sll_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input sll_pkg::sll_lane_in_t laneIn,
  input wire logic [CNT_W-1:0] threshold,
  input wire logic clearCounts,
  output logic [7:0] statusByte,
  output logic [sll_pkg::ERR_TYPES*CNT_W-1:0] counts
);
  logic [sll_pkg::ERR_TYPES-1:0] errPulse;
  logic [sll_pkg::ERR_TYPES-1:0] overThresh;
  logic [7:0] status_reg;
  logic [7:0] status_next;

  assign errPulse = {laneIn.disparityErr, laneIn.invalidCodeErr, laneIn.misplacedKErr};

  genvar t;
  generate
    for (t = 0; t < sll_pkg::ERR_TYPES; t++) begin : g_err
      logic [CNT_W-1:0] cnt_reg;
      logic [CNT_W-1:0] cnt_next;
      logic [CNT_W-1:0] base;
      logic atMax;
      assign base = clearCounts ? sll_pkg::COUNT_RESET : cnt_reg;
      assign atMax = (base == {CNT_W{1'b1}});
      // Event in a clear cycle still counts once
      assign cnt_next = (errPulse[t] && !atMax) ? base + 1'b1 : base; // RULE12
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          cnt_reg <= sll_pkg::COUNT_RESET;
        end else begin
          cnt_reg <= cnt_next;
        end
      end
      assign overThresh[t] = (cnt_reg >= threshold); // RULE12
      assign counts[t*CNT_W +: CNT_W] = cnt_reg;

      cnt_sat_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE12
        (cnt_reg == {CNT_W{1'b1}}) && !clearCounts |=> cnt_reg == {CNT_W{1'b1}})
        else $error("error counter left saturation");
    end
  endgenerate

  always_comb begin
    status_next = sll_pkg::HEALTH_RESET;
    status_next[sll_pkg::BIT_DISPARITY] = overThresh[2]; // RULE1
    status_next[sll_pkg::BIT_INVALID] = overThresh[1]; // RULE2
    status_next[sll_pkg::BIT_MISPLACED] = overThresh[0]; // RULE3
    status_next[sll_pkg::BIT_DESKEW] = laneIn.deskewOk; // RULE4
    status_next[sll_pkg::BIT_ALIGN] = laneIn.initAlignOk; // RULE5
    status_next[sll_pkg::BIT_CHECKSUM] = laneIn.checksumOk; // RULE6
    status_next[sll_pkg::BIT_FRAME] = laneIn.frameLocked; // RULE7
    status_next[sll_pkg::BIT_SYMBOL] = laneIn.symbolLocked; // RULE8
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_reg <= sll_pkg::HEALTH_RESET; // RULE11
    end else begin
      status_reg <= status_next;
    end
  end

  assign statusByte = status_reg;

  disp_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
    !$past(sys_rst) |-> statusByte[7] == ($past(counts[2*CNT_W +: CNT_W]) >= $past(threshold)))
    else $error("disparity flag disagrees with count and threshold");
  invalid_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
    !$past(sys_rst) |-> statusByte[6] == ($past(counts[CNT_W +: CNT_W]) >= $past(threshold)))
    else $error("invalid code flag disagrees with count and threshold");
  misplaced_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
    !$past(sys_rst) |-> statusByte[5] == ($past(counts[0 +: CNT_W]) >= $past(threshold)))
    else $error("misplaced control flag disagrees with count and threshold");
  deskew_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE4
    $rose(laneIn.deskewOk) |=> statusByte[4])
    else $error("deskew bit did not follow lane");
  align_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE5
    $fell(laneIn.initAlignOk) |=> !statusByte[3])
    else $error("alignment bit did not drop");
  checksum_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE6
    laneIn.checksumOk [*2] |-> statusByte[2])
    else $error("checksum bit did not follow lane");
  frame_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE7
    !$past(sys_rst) |-> statusByte[1] == $past(laneIn.frameLocked))
    else $error("frame bit did not follow lane");
  symbol_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE8
    !$past(sys_rst) |-> statusByte[0] == $past(laneIn.symbolLocked))
    else $error("symbol lock bit did not follow lane");
  status_reset_a: assert property (@(posedge ref_clk) // RULE11
    sys_rst |=> statusByte == 8'h00)
    else $error("status byte not zero after reset");
endmodule

//--- tb/sll_lane_tx_model.sv
// Lane transmitter model: error pulses and sync levels per lane
`timescale 1ns/1ps
module sll_lane_tx_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cmdGo,
  input wire logic [2:0] cmdLane,
  input wire logic [1:0] cmdType,
  input wire logic [9:0] cmdCount,
  input wire logic [4:0] syncLvl [sll_pkg::NUM_LANES],
  output sll_pkg::sll_lane_in_t laneOut [sll_pkg::NUM_LANES],
  output logic txBusy
);
  logic [9:0] leftReg;
  logic [2:0] laneReg;
  logic [1:0] typeReg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      leftReg <= 10'h000;
    end else if (cmdGo) begin
      leftReg <= cmdCount;
      laneReg <= cmdLane;
      typeReg <= cmdType;
    end else if (leftReg != 10'h000) begin
      leftReg <= leftReg - 10'h001;
    end
  end
  assign txBusy = cmdGo || (leftReg != 10'h000);
  // One error symbol per high cycle, sync bits as levels
  always_comb begin
    for (int i = 0; i < sll_pkg::NUM_LANES; i++) begin
      laneOut[i] = {3'h0, syncLvl[i]};
      if (leftReg != 10'h000 && laneReg == i[2:0]) begin
        laneOut[i][7:5] = 3'h4 >> typeReg;
      end
    end
  end
endmodule

//--- tb/sll_link_status_tb.sv
// Testbench for the lane status register bank
`timescale 1ns/1ps
module sll_link_status_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [13:0] avsAddress = 14'h0000;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h00000000;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  sll_pkg::sll_lane_in_t laneIn [sll_pkg::NUM_LANES];
  logic [4:0] syncLvl [sll_pkg::NUM_LANES];
  logic [7:0] threshold;
  logic skipAlign;
  logic cmdGo = 1'b0;
  logic [2:0] cmdLane = 3'h0;
  logic [1:0] cmdType = 2'h0;
  logic [9:0] cmdCount = 10'h000;
  logic txBusy;
  logic [31:0] rdData;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  sll_link_status dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(4'hf), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .laneIn(laneIn), .errorCountThreshold(threshold), .skipAlignmentSequence(skipAlign));
  sll_lane_tx_model tx (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmdGo(cmdGo),
    .cmdLane(cmdLane), .cmdType(cmdType), .cmdCount(cmdCount), .syncLvl(syncLvl),
    .laneOut(laneIn), .txBusy(txBusy));
  initial begin
    for (int i = 0; i < sll_pkg::NUM_LANES; i++) syncLvl[i] = 5'h00;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] idx, output logic [31:0] d);
    avsAddress <= {idx, 2'b00};
    avsRead <= 1'b1;
    do @(posedge ref_clk); while (avsWaitrequest !== 1'b0);
    d = avsReaddata;
    avsRead <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    avsAddress <= {idx, 2'b00};
    avsWritedata <= d;
    avsWrite <= 1'b1;
    do @(posedge ref_clk); while (avsWaitrequest !== 1'b0);
    avsWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic pulses(input logic [2:0] ln, input logic [1:0] ty, input logic [9:0] n);
    cmdLane <= ln;
    cmdType <= ty;
    cmdCount <= n;
    cmdGo <= 1'b1;
    @(posedge ref_clk);
    cmdGo <= 1'b0;
    do @(posedge ref_clk); while (txBusy !== 1'b0);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_reset();
    rd(sll_pkg::IDX_LANE6_HEALTH, rdData); chk(rdData, 32'h0);
    rd(sll_pkg::IDX_LANE7_HEALTH, rdData); chk(rdData, 32'h0);
    rd(sll_pkg::IDX_THRESHOLD, rdData); chk(rdData, 32'hff);
    rd(12'h7ff, rdData); chk(rdData, 32'h0);
    wr(sll_pkg::IDX_LANE6_HEALTH, 32'hff);
    rd(sll_pkg::IDX_LANE6_HEALTH, rdData); chk(rdData, 32'h0);
  endtask
  task automatic t_sync();
    for (int b = 0; b < 5; b++) begin
      syncLvl[6] <= 5'h01 << b;
      syncLvl[7] <= ~(5'h01 << b);
      repeat (2) @(posedge ref_clk);
      rd(sll_pkg::IDX_LANE6_HEALTH, rdData);
      chk(rdData, {27'h0, 5'h01 << b});
      rd(sll_pkg::IDX_LANE7_HEALTH, rdData);
      chk(rdData, {27'h0, ~(5'h01 << b)});
    end
    syncLvl[6] <= 5'h00;
    syncLvl[7] <= 5'h00;
  endtask
  task automatic t_errors();
    wr(sll_pkg::IDX_THRESHOLD, 32'h03);
    chk({24'h0, threshold}, 32'h03);
    for (int t = 0; t < 3; t++) begin
      wr(sll_pkg::IDX_CONTROL, 32'h02);
      pulses(3'h6, t[1:0], 10'h002);
      rd(sll_pkg::IDX_LANE6_HEALTH, rdData); chk(rdData, 32'h0);
      pulses(3'h6, t[1:0], 10'h001);
      rd(sll_pkg::IDX_LANE6_HEALTH, rdData); chk(rdData, 32'h80 >> t);
      rd(sll_pkg::IDX_LANE7_HEALTH, rdData); chk(rdData, 32'h0);
      rd(12'h4d8 + t[11:0], rdData); chk(rdData, 32'h03);
    end
    wr(sll_pkg::IDX_THRESHOLD, 32'hff);
    wr(sll_pkg::IDX_CONTROL, 32'h02);
    pulses(3'h7, 2'h0, 10'h12c);
    rd(12'h4dc, rdData); chk(rdData, 32'hff);
    rd(sll_pkg::IDX_LANE7_HEALTH, rdData); chk(rdData, 32'h80);
  endtask
  task automatic t_midreset();
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk({24'h0, threshold}, 32'hff);
    rd(12'h4dc, rdData); chk(rdData, 32'h0);
    rd(sll_pkg::IDX_LANE7_HEALTH, rdData); chk(rdData, 32'h0);
  endtask
  task automatic t_skip();
    syncLvl[6] <= 5'h01;
    wr(sll_pkg::IDX_CONTROL, 32'h01);
    chk({31'h0, skipAlign}, 32'h1);
    rd(sll_pkg::IDX_LANE6_HEALTH, rdData);
    chk(rdData & 32'h1, 32'h1);
    wr(sll_pkg::IDX_CONTROL, 32'h00);
    chk({31'h0, skipAlign}, 32'h0);
    wr(sll_pkg::IDX_THRESHOLD, 32'h00);
    rd(sll_pkg::IDX_LANE6_HEALTH, rdData); chk(rdData, 32'he1);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_sync();
    t_errors();
    t_midreset();
    t_skip();
    final_report();
  end
endmodule
